/* pbc_ctrl.sv */
// Purpose: host controller that runs band select calibration over the 3-wire port
// Assumes: device samples serial data on rising clock, drives read data after falling
// Notes: software orders and observes it over Avalon-MM; one level interrupt
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pbc_ctrl #(
   parameter int unsigned LOCK_TIMEOUT = pbc_pkg::LOCK_TIMEOUT_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   output pbc_pkg::pbc_pins_t ser_pins,
   input wire logic ser_sdio_in,
   input wire logic lock_pin,
   output logic ref_clk_enable
);
   pbc_pkg::pbc_st_t s;
   pbc_pkg::pbc_st_t next_s;
   logic [31:0] wmask;
   localparam int TMO_W_L = pbc_pkg::TMO_W;
   logic lock_ok;
   logic [TMO_W_L-1:0] tmo_limit;
   logic [1:0] irq_ev;

   assign tmo_limit = LOCK_TIMEOUT[TMO_W_L-1:0];
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign lock_ok = s.ser_rd[pbc_pkg::LOCK_BIT] | s.lock_sy[1];

   // one serial frame: instruction byte then data byte, msb first
   function automatic pbc_pkg::pbc_ser_t launch(input logic rd, input logic [4:0] addr,
                                                input logic [7:0] data);
      pbc_pkg::pbc_ser_t f;
      f.busy = 1'b1;
      f.rd = rd;
      f.csb = 1'b0;
      f.sclk = 1'b0;
      f.oe = 1'b1;
      f.sh = {rd, 2'h0, addr, data};
      f.cnt = 4'h0;
      f.half = 3'h0;
      return f;
   endfunction

   function automatic logic [5:0] adjust(input logic [5:0] band, input logic [2:0] temp);
      logic [7:0] delta;
      logic [7:0] sum;
      delta = 8'h00;
      sum = 8'h00;
      case (temp)
         pbc_pkg::T_M40_M30: delta = (band >= pbc_pkg::BAND_UPPER) ? 8'h03 : 8'h02;
         pbc_pkg::T_M30_M10: delta = 8'h02;
         pbc_pkg::T_M10_P15: delta = 8'h01;
         pbc_pkg::T_P15_P55: delta = 8'h00;
         default: delta = 8'hFF;
      endcase
      sum = {2'h0, band} + delta;
      // negative results wrap to bit 7; both ends are clamped
      if (sum[7]) begin
         sum = 8'h00;
      end else if (sum > {2'h0, pbc_pkg::BAND_MAX}) begin
         sum = {2'h0, pbc_pkg::BAND_MAX};
      end
      return sum[5:0];
   endfunction

   always_comb begin
      next_s = s;
      next_s.ser_done = 1'b0;
      next_s.irq_stat = 2'b00;
      next_s.lock_sy = {s.lock_sy[0], lock_pin};
      next_s.sdio_sy = {s.sdio_sy[0], ser_sdio_in};

      // serial engine; read data taken on the falling clock edge
      if (s.ser.busy) begin
         if (s.ser.half == pbc_pkg::SCLK_HALF_CYC - 3'h1) begin
            next_s.ser.half = 3'h0;
            if (!s.ser.sclk) begin
               next_s.ser.sclk = 1'b1;
            end else begin
               next_s.ser.sclk = 1'b0;
               next_s.ser.sh = {s.ser.sh[14:0], 1'b0};
               if (s.ser.rd && s.ser.cnt >= pbc_pkg::SER_DATA_FIRST) begin
                  next_s.ser_rd = {s.ser_rd[6:0], s.sdio_sy[1]};
               end
               if (s.ser.cnt == pbc_pkg::SER_LAST_BIT) begin
                  next_s.ser.busy = 1'b0;
                  next_s.ser.csb = 1'b1;
                  next_s.ser.oe = 1'b0;
                  next_s.ser_done = 1'b1;
               end else begin
                  next_s.ser.cnt = s.ser.cnt + 4'h1;
                  // release the data line once the instruction byte is out
                  next_s.ser.oe = !s.ser.rd || (s.ser.cnt + 4'h1 < pbc_pkg::SER_DATA_FIRST);
               end
            end
         end else begin
            next_s.ser.half = s.ser.half + 3'h1;
         end
      end

      case (s.fsm)
         pbc_pkg::S_IDLE: begin
            if (s.ack && avs_write && avs_address == pbc_pkg::CSR_CTRL && avs_byteenable[0]
                && avs_writedata[pbc_pkg::CTRL_START_BIT]) begin
               next_s.mode = pbc_pkg::pbc_mode_t'(avs_writedata[pbc_pkg::CTRL_MODE_LSB +: 2]);
               next_s.temp = avs_writedata[pbc_pkg::CTRL_TEMP_LSB +: 3];
               next_s.locked = 1'b0;
               if (pbc_pkg::pbc_mode_t'(avs_writedata[pbc_pkg::CTRL_MODE_LSB +: 2])
                   == pbc_pkg::MODE_LOAD) begin
                  // stored or screened band goes straight in, no search
                  next_s.ser = launch(1'b0, pbc_pkg::DEV_BAND_ADDR,
                                      {s.band_load, s.cfg.drive});
                  next_s.adj_band = s.band_load;
                  next_s.fsm = pbc_pkg::S_WR_BAND;
               end else begin
                  next_s.ser = launch(1'b0, pbc_pkg::DEV_DIV_ADDR,
                                      {1'b0, s.cfg.div1, s.cfg.div2, s.cfg.bias});
                  next_s.fsm = pbc_pkg::S_WR_DIV;
               end
            end
         end
         pbc_pkg::S_WR_DIV: begin
            if (s.ser_done) begin
               next_s.ser = launch(1'b0, pbc_pkg::DEV_BW_ADDR, {3'h0, s.cfg.bw});
               next_s.fsm = pbc_pkg::S_WR_BW;
            end
         end
         pbc_pkg::S_WR_BW: begin
            if (s.ser_done) begin
               next_s.ser = launch(1'b0, pbc_pkg::DEV_BAND_ADDR,
                                   {pbc_pkg::BAND_AUTO, s.cfg.drive});
               next_s.fsm = pbc_pkg::S_WR_AUTO;
            end
         end
         pbc_pkg::S_WR_AUTO: begin
            if (s.ser_done) begin
               next_s.tmo = '0;
               next_s.ser = launch(1'b1, pbc_pkg::DEV_LOCK_ADDR, 8'h00);
               next_s.fsm = pbc_pkg::S_POLL;
            end
         end
         pbc_pkg::S_POLL: begin
            if (s.tmo < tmo_limit) begin
               next_s.tmo = s.tmo + 1'b1;
            end
            if (s.ser_done) begin
               if (lock_ok) begin
                  next_s.locked = 1'b1;
                  next_s.ser = launch(1'b1, pbc_pkg::DEV_BAND_ADDR, 8'h00);
                  next_s.fsm = pbc_pkg::S_RD_BAND;
               end else if (s.tmo >= tmo_limit) begin
                  next_s.irq_stat[pbc_pkg::IRQ_ERR] = 1'b1;
                  next_s.fsm = pbc_pkg::S_IDLE;
               end else begin
                  next_s.ser = launch(1'b1, pbc_pkg::DEV_LOCK_ADDR, 8'h00);
               end
            end
         end
         pbc_pkg::S_RD_BAND: begin
            if (s.ser_done) begin
               next_s.rb_band = s.ser_rd[7:pbc_pkg::BAND_LSB];
               next_s.adj_band = adjust(s.ser_rd[7:pbc_pkg::BAND_LSB], s.temp);
               if (s.mode == pbc_pkg::MODE_SENSE) begin
                  next_s.ser = launch(1'b0, pbc_pkg::DEV_BAND_ADDR,
                                      {adjust(s.ser_rd[7:pbc_pkg::BAND_LSB], s.temp),
                                       s.cfg.drive});
                  next_s.fsm = pbc_pkg::S_WR_BAND;
               end else begin
                  // adjusted value left for software to keep in nonvolatile memory
                  next_s.irq_stat[pbc_pkg::IRQ_DONE] = 1'b1;
                  next_s.fsm = pbc_pkg::S_IDLE;
               end
            end
         end
         pbc_pkg::S_WR_BAND: begin
            if (s.ser_done) begin
               next_s.irq_stat[pbc_pkg::IRQ_DONE] = 1'b1;
               next_s.fsm = pbc_pkg::S_IDLE;
            end
         end
         default: next_s.fsm = pbc_pkg::S_IDLE;
      endcase
      // events held apart, so a clear in the same cycle cannot swallow one
      irq_ev = next_s.irq_stat;
      next_s.irq_stat = s.irq_stat | irq_ev;

      // avalon slave: decode on first edge, answer one cycle later
      next_s.ack = (avs_read || avs_write) && !s.ack;
      if ((avs_read || avs_write) && !s.ack) begin
         case (avs_address)
            pbc_pkg::CSR_CTRL: next_s.rdata = {25'h0, s.temp, 1'b0, s.mode, 1'b0};
            pbc_pkg::CSR_CFG: next_s.rdata = {17'h0, s.cfg};
            pbc_pkg::CSR_BAND: next_s.rdata = {26'h0, s.band_load};
            pbc_pkg::CSR_STAT: next_s.rdata = {10'h0, s.adj_band, 2'h0, s.rb_band, 5'h0,
                                               s.lock_sy[1], s.locked,
                                               s.fsm != pbc_pkg::S_IDLE};
            pbc_pkg::CSR_IRQ_STAT: next_s.rdata = {30'h0, s.irq_stat};
            pbc_pkg::CSR_IRQ_MASK: next_s.rdata = {30'h0, s.irq_mask};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end
      if (s.ack && avs_write) begin
         case (avs_address)
            pbc_pkg::CSR_CFG: begin
               // configuration is frozen while a sequence runs
               if (s.fsm == pbc_pkg::S_IDLE) begin
                  next_s.cfg = (s.cfg & ~wmask[14:0]) | (avs_writedata[14:0] & wmask[14:0]);
               end
            end
            pbc_pkg::CSR_BAND: begin
               if (s.fsm == pbc_pkg::S_IDLE) begin
                  next_s.band_load = (s.band_load & ~wmask[5:0])
                                     | (avs_writedata[5:0] & wmask[5:0]);
               end
            end
            pbc_pkg::CSR_IRQ_STAT: begin
               // set wins: an event in this cycle survives its clear
               next_s.irq_stat = (s.irq_stat & ~(avs_writedata[1:0] & wmask[1:0]))
                                 | irq_ev;
            end
            pbc_pkg::CSR_IRQ_MASK: begin
               next_s.irq_mask = (s.irq_mask & ~wmask[1:0]) | (avs_writedata[1:0] & wmask[1:0]);
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
         s.fsm <= pbc_pkg::S_IDLE;
         s.ser.csb <= 1'b1;
         s.cfg <= {pbc_pkg::REF_EN_RST, pbc_pkg::DRIVE_RST, pbc_pkg::BW_RST,
                   pbc_pkg::BIAS_RST, pbc_pkg::DIV2_RST, pbc_pkg::DIV1_RST};
         s.mode <= pbc_pkg::MODE_SENSE;
         s.temp <= pbc_pkg::T_P15_P55;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata = s.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
   assign irq = |(s.irq_stat & s.irq_mask);
   assign ser_pins = {s.ser.csb, s.ser.sclk, s.ser.sh[15], s.ser.oe};
   // reference clock cannot be switched off mid sequence
   assign ref_clk_enable = s.cfg.ref_en || (s.fsm != pbc_pkg::S_IDLE);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_csb_idle: assert property (!s.ser.busy |-> s.ser.csb)
      else $error("chip select low with no frame");
   a_read_release: assert property (s.ser.busy && s.ser.rd
      && s.ser.cnt >= pbc_pkg::SER_DATA_FIRST |-> !s.ser.oe)
      else $error("data line driven during read data phase");
   a_div_frame: assert property ($rose(s.fsm == pbc_pkg::S_WR_DIV) |->
      s.ser.sh[15:8] == {3'h0, pbc_pkg::DEV_DIV_ADDR} && s.ser.sh[6:3] == {s.cfg.div1, s.cfg.div2})
      else $error("divider frame wrong");
   a_bw_frame: assert property ($rose(s.fsm == pbc_pkg::S_WR_BW) |->
      s.ser.sh == {3'h0, pbc_pkg::DEV_BW_ADDR, 3'h0, s.cfg.bw})
      else $error("bandwidth frame wrong");
   a_auto_order: assert property ($rose(s.fsm == pbc_pkg::S_WR_AUTO) |->
      $past(s.fsm) == pbc_pkg::S_WR_BW && s.ser.sh[7:2] == pbc_pkg::BAND_AUTO)
      else $error("auto search not requested after setup");
   a_lock_first: assert property ($rose(s.fsm == pbc_pkg::S_RD_BAND) |->
      $past(s.ser_rd[pbc_pkg::LOCK_BIT]) || $past(s.lock_sy[1]))
      else $error("band read without lock");
   a_timeout_err: assert property (s.fsm == pbc_pkg::S_POLL && s.ser_done && !lock_ok
      && s.tmo >= tmo_limit |=> s.fsm == pbc_pkg::S_IDLE && s.irq_stat[pbc_pkg::IRQ_ERR])
      else $error("timeout did not flag error");
   a_adj_lower: assert property (s.fsm == pbc_pkg::S_RD_BAND && s.ser_done
      && s.temp == pbc_pkg::T_M30_M10 && s.ser_rd[7:2] < 6'h20 |=> s.adj_band == s.rb_band + 6'h2)
      else $error("lower band offset wrong");
   a_adj_upper: assert property (s.fsm == pbc_pkg::S_RD_BAND && s.ser_done
      && s.temp == pbc_pkg::T_M40_M30 && s.ser_rd[7:2] >= 6'h20 && s.ser_rd[7:2] < 6'h3B
      |=> s.adj_band == s.rb_band + 6'h3)
      else $error("upper band offset wrong");
   a_adj_range: assert property (s.adj_band <= pbc_pkg::BAND_MAX
      || s.mode == pbc_pkg::MODE_LOAD)
      else $error("adjusted band out of range");
   a_writeback: assert property ($rose(s.fsm == pbc_pkg::S_WR_BAND)
      && s.mode == pbc_pkg::MODE_SENSE
      |-> s.ser.sh[7:2] == s.adj_band && $past(s.fsm) == pbc_pkg::S_RD_BAND)
      else $error("write back not adjusted band");
   a_load_skip: assert property ($rose(s.fsm == pbc_pkg::S_WR_BAND)
      && s.mode == pbc_pkg::MODE_LOAD
      |-> $past(s.fsm) == pbc_pkg::S_IDLE && s.ser.sh[7:2] == s.band_load)
      else $error("load did not skip search");
   a_reference_clock_input_on: assert property (s.fsm != pbc_pkg::S_IDLE |-> ref_clk_enable)
      else $error("reference clock off during sequence");
   // frame framing and flag bookkeeping
   a_poll_order: assert property ($rose(s.fsm == pbc_pkg::S_POLL) |->
      $past(s.fsm) == pbc_pkg::S_WR_AUTO && s.tmo == '0
      && s.ser.sh[15:8] == {1'b1, 2'h0, pbc_pkg::DEV_LOCK_ADDR})
      else $error("lock poll not started after auto search");
   a_rd_frame: assert property ($rose(s.fsm == pbc_pkg::S_RD_BAND) |->
      s.locked && s.ser.sh[15:8] == {1'b1, 2'h0, pbc_pkg::DEV_BAND_ADDR})
      else $error("band readback frame wrong");
   a_err_no_read: assert property ($rose(s.irq_stat[pbc_pkg::IRQ_ERR]) |->
      s.fsm == pbc_pkg::S_IDLE && !s.locked && !s.ser.busy)
      else $error("error flagged with sequence still running");
   a_done_sticky: assert property (s.irq_stat[pbc_pkg::IRQ_DONE]
      && !(s.ack && avs_write && avs_address == pbc_pkg::CSR_IRQ_STAT)
      |=> s.irq_stat[pbc_pkg::IRQ_DONE])
      else $error("done flag dropped without a clear");
   a_frame_start: assert property ($rose(s.ser.busy) |-> $past(s.ser.csb) && !s.ser.csb)
      else $error("frame started without chip select gap");
   a_sclk_idle: assert property (!s.ser.busy |-> !s.ser.sclk && !s.ser.oe)
      else $error("serial clock or data driven with no frame");
endmodule
`default_nettype wire

/* pbc_dev_model.sv */
// Purpose: behavioural model of the converter's serial port, lock logic and band registers
// Assumes: samples data on rising serial clock, drives read data after falling edges
// Notes: an undriven data line shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module pbc_dev_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire pbc_pkg::pbc_pins_t pins,
   input wire logic [5:0] auto_band,
   input wire logic [15:0] lock_dly,
   output logic sdio_line,
   output logic lock_pin,
   output logic searching,
   output logic early_rd,
   output logic [7:0] band_reg,
   output logic [7:0] div_reg,
   output logic [7:0] bw_reg,
   output logic [7:0] n_auto
);
   logic sclk_q, drv_en, drv, last, rd_fr;
   logic [4:0] cnt;
   logic [15:0] sh, tmr;
   logic [7:0] rd_byte;
   // no pull on the line, so a stale level must not look like data
   assign sdio_line = pins.sdio_oe ? pins.sdio_o : (drv_en ? drv : ~last);
   always_ff @(posedge clk) begin
      sclk_q <= pins.sclk;
      last <= sdio_line;
      if (!rst_n) begin
         {cnt, drv_en, lock_pin, searching, early_rd, n_auto, rd_fr} <= '0;
         {band_reg, div_reg, bw_reg, tmr} <= '0;
      end else begin
         if (searching) begin
            tmr <= tmr + 16'h0001;
            if (tmr == lock_dly) begin
               lock_pin <= 1'b1;
               searching <= 1'b0;
               band_reg[7:2] <= auto_band;
            end
         end
         if (pins.csb) begin
            cnt <= '0;
            drv_en <= 1'b0;
         end else if (pins.sclk && !sclk_q) begin
            sh <= {sh[14:0], sdio_line};
            cnt <= cnt + 5'h01;
            if (cnt == 5'h07) begin
               rd_fr <= sh[6];
               case ({sh[3:0], sdio_line})
                  5'h00: rd_byte <= {6'h00, lock_pin, 1'b0};
                  5'h08: rd_byte <= band_reg;
                  5'h09: rd_byte <= div_reg;
                  5'h0A: rd_byte <= bw_reg;
                  default: rd_byte <= 8'h00;
               endcase
               if ({sh[3:0], sdio_line} == 5'h08 && sh[6] && searching) begin
                  early_rd <= 1'b1;
               end
            end
            if (cnt == 5'h0F && !sh[14]) begin
               case (sh[11:7])
                  5'h08: begin
                     band_reg <= {sh[6:0], sdio_line};
                     searching <= (sh[6:1] == 6'h3F);
                     if (sh[6:1] == 6'h3F) begin
                        lock_pin <= 1'b0;
                        tmr <= '0;
                        n_auto <= n_auto + 8'h01;
                     end
                  end
                  5'h09: div_reg <= {sh[6:0], sdio_line};
                  5'h0A: bw_reg <= {sh[6:0], sdio_line};
                  default: ;
               endcase
            end
         end else if (!pins.sclk && sclk_q && rd_fr && cnt >= 5'h08) begin
            drv_en <= 1'b1;
            drv <= rd_byte[3'(5'h0F - cnt)];
         end
      end
   end
endmodule
`default_nettype wire

/* pbc_pkg.sv */
// Purpose: shared constants and types of the band select calibration controller
// Assumes: 40 MHz system clock, 3-wire serial port with 8-bit instruction and 8-bit data
// Notes: device register map is the far side; controller registers sit on Avalon-MM
package pbc_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int LOCK_EXPECT_US = 5000;
   localparam int LOCK_TIMEOUT_US = 6000;
   localparam int LOCK_TIMEOUT_CYC = LOCK_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam int TMO_W = 20;
   // serial clock half period in system cycles (5 MHz serial clock)
   localparam logic [2:0] SCLK_HALF_CYC = 3'h4;
   localparam logic [3:0] SER_LAST_BIT = 4'hF;
   localparam logic [3:0] SER_DATA_FIRST = 4'h8;
   // far-side device registers and fields
   localparam logic [4:0] DEV_LOCK_ADDR = 5'h00;
   localparam logic [4:0] DEV_BAND_ADDR = 5'h08;
   localparam logic [4:0] DEV_DIV_ADDR = 5'h09;
   localparam logic [4:0] DEV_BW_ADDR = 5'h0A;
   localparam int INSTR_READ_BIT = 7;
   localparam int LOCK_BIT = 1;
   localparam int BAND_LSB = 2;
   localparam int DIV1_LSB = 5;
   localparam int DIV2_LSB = 3;
   localparam logic [5:0] BAND_AUTO = 6'h3F;
   localparam logic [5:0] BAND_MAX = 6'h3E;
   localparam logic [5:0] BAND_UPPER = 6'h20;
   // controller registers, byte addresses
   localparam logic [4:0] CSR_CTRL = 5'h00;
   localparam logic [4:0] CSR_CFG = 5'h04;
   localparam logic [4:0] CSR_BAND = 5'h08;
   localparam logic [4:0] CSR_STAT = 5'h0C;
   localparam logic [4:0] CSR_IRQ_STAT = 5'h10;
   localparam logic [4:0] CSR_IRQ_MASK = 5'h14;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_TEMP_LSB = 4;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   // configuration reset values
   localparam logic [1:0] DIV1_RST = 2'h0;
   localparam logic [1:0] DIV2_RST = 2'h0;
   localparam logic [2:0] BIAS_RST = 3'h3;
   localparam logic [4:0] BW_RST = 5'h0F;
   localparam logic [1:0] DRIVE_RST = 2'h3;
   localparam logic REF_EN_RST = 1'b1;

   typedef enum logic [1:0] {
      MODE_SENSE = 2'h0,
      MODE_STORE = 2'h1,
      MODE_LOAD = 2'h2
   } pbc_mode_t;

   // temperature band codes written by software
   localparam logic [2:0] T_M40_M30 = 3'h0;
   localparam logic [2:0] T_M30_M10 = 3'h1;
   localparam logic [2:0] T_M10_P15 = 3'h2;
   localparam logic [2:0] T_P15_P55 = 3'h3;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_WR_DIV = 7'h02,
      S_WR_BW = 7'h04,
      S_WR_AUTO = 7'h08,
      S_POLL = 7'h10,
      S_RD_BAND = 7'h20,
      S_WR_BAND = 7'h40
   } pbc_state_t;

   typedef struct packed {
      logic ref_en;
      logic [1:0] drive;
      logic [4:0] bw;
      logic [2:0] bias;
      logic [1:0] div2;
      logic [1:0] div1;
   } pbc_cfg_t;

   typedef struct packed {
      logic busy;
      logic rd;
      logic csb;
      logic sclk;
      logic oe;
      logic [15:0] sh;
      logic [3:0] cnt;
      logic [2:0] half;
   } pbc_ser_t;

   typedef struct packed {
      logic csb;
      logic sclk;
      logic sdio_o;
      logic sdio_oe;
   } pbc_pins_t;

   typedef struct packed {
      pbc_state_t fsm;
      pbc_ser_t ser;
      logic ser_done;
      logic [7:0] ser_rd;
      pbc_cfg_t cfg;
      pbc_mode_t mode;
      logic [2:0] temp;
      logic [5:0] band_load;
      logic [5:0] rb_band;
      logic [5:0] adj_band;
      logic locked;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [TMO_W-1:0] tmo;
      logic ack;
      logic [31:0] rdata;
      logic [1:0] lock_sy;
      logic [1:0] sdio_sy;
   } pbc_st_t;
endpackage

/* pbc_tb.sv */
// Purpose: self-checking bench of the band select calibration controller
// Assumes: device model on the serial port, Avalon master with one request at a time
// Notes: lock timeout shortened to 2000 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [5:0] ab = '0;
   logic [15:0] lockd = 16'h012C;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, irq, sdio, lockp, refen, searching, early_rd;
   logic [7:0] band_reg, div_reg, bw_reg, n_auto;
   pbc_pkg::pbc_pins_t pins;
   int err_total = 0;
   int n_checks = 0;
   always #12.5 clk = ~clk;
   pbc_ctrl #(.LOCK_TIMEOUT(2000)) dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq(irq), .ser_pins(pins), .ser_sdio_in(sdio), .lock_pin(lockp), .ref_clk_enable(refen));
   pbc_dev_model dev (.clk(clk), .rst_n(rst_n), .pins(pins), .auto_band(ab), .lock_dly(lockd),
      .sdio_line(sdio), .lock_pin(lockp), .searching(searching), .early_rd(early_rd),
      .band_reg(band_reg), .div_reg(div_reg), .bw_reg(bw_reg), .n_auto(n_auto));
   task automatic results();
      if (err_total == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 100) err_total++;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      av(1'b1, a, d, q);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 30000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 30000) err_total++;
   endtask
   function automatic logic [5:0] adj(input logic [5:0] b, input logic [2:0] t);
      int v;
      v = int'(b);
      if (t >= 3'h4) v = v - 1;
      else if (t == 3'h2) v = v + 1;
      else if (t < 3'h2) v = v + ((b < 6'h20 || t == 3'h1) ? 2 : 3);
      if (v < 0) v = 0;
      if (v > 62) v = 62;
      return 6'(v);
   endfunction
   // reference clock held only by busy here, since ref_en is cleared
   task automatic run(input logic [1:0] m, input logic [2:0] t, input logic [5:0] b,
                      input logic [1:0] d1, input logic [1:0] d2);
      logic [31:0] q;
      logic [7:0] na;
      logic [5:0] e;
      na = n_auto;
      e = adj(b, t);
      ab <= b;
      lockd <= 16'(100 + $urandom_range(500, 0));
      wr(pbc_pkg::CSR_CFG, {17'h0, 1'b0, 2'h3, 5'h0F, 3'h3, d2, d1});
      wr(pbc_pkg::CSR_BAND, {26'h0, b});
      wr(pbc_pkg::CSR_CTRL, {25'h0, t, 1'b0, m, 1'b1});
      wait_irq();
      av(1'b0, pbc_pkg::CSR_IRQ_STAT, 32'h0, q);
      chk(q, 32'h0000_0001);
      if (m == 2'h2) begin
         chk(32'(band_reg), {24'h0, b, 2'h3});
         chk(32'(n_auto), 32'(na));
      end else begin
         chk(32'(n_auto), 32'(na) + 32'h1);
         chk(32'(div_reg), {24'h0, 1'b0, d1, d2, 3'h3});
         chk(32'(bw_reg), 32'h0000_000F);
         av(1'b0, pbc_pkg::CSR_STAT, 32'h0, q);
         chk(32'(q[13:8]), 32'(b));
         chk(32'(q[21:16]), 32'(e));
         chk(32'(band_reg), {24'h0, (m == 2'h0) ? e : b, 2'h3});
      end
      chk(32'(early_rd), 32'h0);
      av(1'b0, pbc_pkg::CSR_CTRL, 32'h0, q);
      chk(q, {25'h0, t, 1'b0, m, 1'b0});
      wr(pbc_pkg::CSR_IRQ_STAT, 32'h0000_0001);
      @(posedge clk);
      chk(32'(irq), 32'h0);
   endtask
   always @(posedge clk) begin
      if (searching) chk(32'(refen), 32'h1);
   end
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      results();
   end
   initial begin
      logic [31:0] q;
      int n;
      logic [5:0] cb [6];
      logic [2:0] ct [6];
      cb = '{6'd0, 6'd31, 6'd32, 6'd62, 6'd62, 6'd0};
      ct = '{3'h0, 3'h1, 3'h0, 3'h7, 3'h0, 3'h4};
      void'($urandom(38661));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      av(1'b0, pbc_pkg::CSR_CFG, 32'h0, q);
      chk(q, {17'h0, pbc_pkg::REF_EN_RST, pbc_pkg::DRIVE_RST, pbc_pkg::BW_RST,
              pbc_pkg::BIAS_RST, pbc_pkg::DIV2_RST, pbc_pkg::DIV1_RST});
      av(1'b0, pbc_pkg::CSR_IRQ_MASK, 32'h0, q);
      chk(q, 32'h0000_0000);
      av(1'b0, 5'h18, 32'h0, q);
      chk(q, 32'h0000_0000);
      chk(32'(pins.csb), 32'h1);
      // masked run: status sets, line stays low until unmasked
      wr(pbc_pkg::CSR_BAND, 32'h0000_0015);
      wr(pbc_pkg::CSR_CTRL, 32'h0000_0005);
      n = 0;
      do begin
         av(1'b0, pbc_pkg::CSR_STAT, 32'h0, q);
         n++;
      end while (q[0] !== 1'b0 && n < 200);
      chk(32'(irq), 32'h0);
      chk(32'(band_reg), 32'h0000_0057);
      av(1'b0, pbc_pkg::CSR_IRQ_STAT, 32'h0, q);
      chk(q, 32'h0000_0001);
      wr(pbc_pkg::CSR_IRQ_MASK, 32'h0000_0003);
      @(posedge clk);
      chk(32'(irq), 32'h1);
      wr(pbc_pkg::CSR_IRQ_STAT, 32'h0000_0001);
      for (int i = 0; i < 6; i++) run(2'h0, ct[i], cb[i], 2'($urandom), 2'($urandom));
      for (int i = 0; i < 9; i++) begin
         run(2'(i % 3), 3'($urandom), 6'($urandom_range(62, 0)), 2'($urandom), 2'($urandom));
      end
      // lock never comes: error raised, no readback or write back
      lockd <= 16'hFFFF;
      wr(pbc_pkg::CSR_CFG, 32'h0000_7F98);
      wr(pbc_pkg::CSR_CTRL, 32'h0000_0031);
      wait_irq();
      av(1'b0, pbc_pkg::CSR_IRQ_STAT, 32'h0, q);
      chk(q, 32'h0000_0002);
      av(1'b0, pbc_pkg::CSR_STAT, 32'h0, q);
      chk(32'(q[1]), 32'h0);
      chk(32'(band_reg), 32'h0000_00FF);
      results();
   end
endmodule
`default_nettype wire
